// ---- design/tac_pkg.sv ----
// Function
// RULE1 - mode 0: talk addressing starts the sequence
// RULE2 - mode 1: talk addressing halts the sequence
// RULE3 - mode 2: group execute trigger starts the sequence
// RULE4 - mode 3: group execute trigger halts the sequence
// RULE5 - mode 4: an execute character starts the sequence
// RULE6 - mode 5: an execute character halts the sequence
// RULE7 - mode 6: an external pulse starts the sequence
// RULE8 - mode 7: an external pulse halts the sequence
// RULE9 - bus clear defaults select mode 6, external pulse start
// RULE10 - bus, external input and panel key trigger step, cycle or continuous runs
// RULE11 - single cycle steps every programmed location in turn, one dwell each
// RULE12 - a new trigger mode takes effect when its command string executes
// RULE13 - default terminator is carriage return then line feed
// RULE14 - power up, device clear and selected device clear restore the default
// RULE15 - terminator command loads the following characters as terminator
// RULE16 - capitals, digits, blank, plus, minus, slash, comma, period, e are not terminators
// RULE17 - two following characters give both in order, one gives one
// RULE18 - delete after the terminator command means no terminator at all
// RULE19 - terminator goes after every data string and status word, in given order
// RULE20 - illegal option with error service enabled requests service, sets error bits
// RULE21 - serial poll read releases the request and clears latched status bits
// RULE22 - status bit 6 shows service requested, bit 5 flags an error
// RULE23 - stimuli not matching the selected mode leave the sequencer unchanged
`default_nettype none

package tac_pkg;

    // ----------------------------------------------------------------
    // trigger modes
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_START_TALK = 3'h0;
    localparam logic [2:0] MODE_STOP_TALK = 3'h1;
    localparam logic [2:0] MODE_START_GET = 3'h2;
    localparam logic [2:0] MODE_STOP_GET = 3'h3;
    localparam logic [2:0] MODE_START_EXEC = 3'h4;
    localparam logic [2:0] MODE_STOP_EXEC = 3'h5;
    localparam logic [2:0] MODE_START_EXT = 3'h6;
    localparam logic [2:0] MODE_STOP_EXT = 3'h7;
    localparam logic [2:0] MODE_DEFAULT = MODE_START_EXT;

    // ----------------------------------------------------------------
    // command characters
    // ----------------------------------------------------------------
    localparam logic [7:0] CHR_CR = 8'h0D;
    localparam logic [7:0] CHR_LF = 8'h0A;
    localparam logic [7:0] CHR_DEL = 8'h7F;
    localparam logic [7:0] CMD_TRIG = 8'h54;
    localparam logic [7:0] CMD_TERM = 8'h59;
    localparam logic [7:0] CMD_EXEC = 8'h58;
    localparam logic [7:0] CHR_MODE_LO = 8'h30;
    localparam logic [7:0] CHR_MODE_HI = 8'h37;

    // ----------------------------------------------------------------
    // terminator defaults
    // ----------------------------------------------------------------
    localparam logic [1:0] TERM_LEN_MAX = 2'h2;
    localparam logic [1:0] TERM_LEN_DEFAULT = 2'h2;
    localparam logic [7:0] TERM_C0_DEFAULT = CHR_CR;
    localparam logic [7:0] TERM_C1_DEFAULT = CHR_LF;

    // ----------------------------------------------------------------
    // sequencer and status byte
    // ----------------------------------------------------------------
    localparam logic [6:0] LOC_FIRST = 7'h01;
    localparam logic [6:0] LOC_STEP = 7'h01;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int STAT_RQS_BIT = 6;
    localparam int STAT_ERR_BIT = 5;

    typedef enum logic [1:0] {
        TAC_SEQ_STEP = 2'h0,
        TAC_SEQ_CYCLE = 2'h1,
        TAC_SEQ_CONT = 2'h2
    } tac_seq_mode_t;

    // chars never allowed in a terminator
    function automatic logic tac_term_forbidden(input logic [7:0] c);
        return (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h30 && c <= 8'h39) || c == 8'h20 || c == 8'h2B
            || c == 8'h2D || c == 8'h2F || c == 8'h2C || c == 8'h2E || c == 8'h65;
    endfunction : tac_term_forbidden

    // stimulus counts only in the given mode
    function automatic logic tac_mode_hit(input logic [2:0] mode, input logic [2:0] want, input logic stim);
        return stim && (mode == want);
    endfunction : tac_mode_hit

endpackage : tac_pkg

`default_nettype wire

// ---- design/tac_term_if.sv ----
`default_nettype none

interface tac_term_if;
    logic [1:0] len;
    logic [7:0] c0;
    logic [7:0] c1;
    modport cfg (output len, c0, c1);
    modport tx (input len, c0, c1);
endinterface : tac_term_if

`default_nettype wire

// ---- design/tac_term_tx.sv ----
`default_nettype none

module tac_term_tx (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // terminator setting
    tac_term_if.tx term,
    // formatter side
    input wire logic i_send,
    input wire logic i_ready,
    output logic o_valid,
    output logic [7:0] o_char,
    output logic o_done
);
    import tac_pkg::*;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_FIRST = 3'b010,
        TX_SECOND = 3'b100
    } tac_tx_state_t;

    tac_tx_state_t state;
    logic [7:0] second;

    // ----------------------------------------------------------------
    // terminator emission
    // ----------------------------------------------------------------
    // chars copied at the send request, so a reprogram cannot mix old and new
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= TX_IDLE;
            o_char <= 8'h00;
            second <= 8'h00;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state)
                TX_IDLE: begin
                    if (i_send) begin
                        o_char <= term.c0; // RULE19
                        second <= term.c1;
                        if (term.len == 2'h0) begin
                            o_done <= 1'b1; // RULE18
                        end else if (term.len == 2'h1) begin
                            state <= TX_SECOND; // RULE17
                        end else begin
                            state <= TX_FIRST; // RULE17
                        end
                    end
                end
                TX_FIRST: begin
                    if (i_ready) begin
                        o_char <= second; // RULE19
                        state <= TX_SECOND;
                    end
                end
                TX_SECOND: begin
                    if (i_ready) begin
                        o_done <= 1'b1;
                        state <= TX_IDLE;
                    end
                end
                default: begin
                    state <= TX_IDLE;
                end
            endcase
        end
    end

    assign o_valid = (state != TX_IDLE);

endmodule : tac_term_tx

`default_nettype wire

// ---- design/tac_trig_term.sv ----
`default_nettype none

module tac_trig_term (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // bus events, one-cycle pulses
    input wire logic i_talk_addr,
    input wire logic i_get,
    input wire logic i_dcl,
    input wire logic i_sdc,
    input wire logic i_spoll_read,
    // command character stream
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_char,
    // other stimuli
    input wire logic i_ext_trig,
    input wire logic i_panel_key,
    // sequencer
    input wire tac_pkg::tac_seq_mode_t i_seq_mode,
    input wire logic [6:0] i_last_loc,
    input wire logic i_dwell_done,
    output logic o_running,
    output logic [6:0] o_mem_loc,
    output logic o_step_apply,
    output logic o_cycle_end,
    output logic [2:0] o_trig_mode,
    // status byte
    input wire logic i_srq_err_en,
    input wire logic i_illegal_option,
    input wire logic [7:0] i_live_status,
    output logic o_srq,
    output logic [7:0] o_status_byte,
    // terminator to output formatter
    input wire logic i_fmt_end,
    input wire logic i_term_ready,
    output logic o_term_valid,
    output logic [7:0] o_term_char,
    output logic o_term_done
);
    import tac_pkg::*;

    typedef enum logic [2:0] {
        P_IDLE = 3'b001,
        P_TMODE = 3'b010,
        P_TERM = 3'b100
    } tac_parse_state_t;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    tac_parse_state_t pstate;
    tac_parse_state_t next_pstate;
    logic [2:0] mode;
    logic [2:0] pend_mode;
    logic pend_mode_vld;
    logic [1:0] y_cnt;
    logic [7:0] y_c0;
    logic [7:0] y_c1;
    logic y_ovf;
    logic [1:0] pend_len;
    logic [7:0] pend_c0;
    logic [7:0] pend_c1;
    logic pend_term_vld;
    logic [1:0] term_len;
    logic [7:0] term_c0;
    logic [7:0] term_c1;
    logic bus_clear;
    logic t_char;
    logic t_ok;
    logic y_char;
    logic y_end;
    logic y_good;
    logic [1:0] y_len;
    logic idle_char;
    logic x_exec;
    logic illegal_int;
    logic err_ev;
    logic ext_prev;
    logic ext_pulse;
    logic start_ev;
    logic halt_ev;
    logic srq;
    logic err;
    logic [7:0] snap;

    tac_term_if term_cfg ();

    assign bus_clear = i_dcl || i_sdc;

    // ----------------------------------------------------------------
    // command character decode
    // ----------------------------------------------------------------
    // a forbidden char closes a terminator field
    // and is decoded as a command char too
    always_comb begin
        t_char = i_cmd_valid && (pstate == P_TMODE);
        t_ok = t_char && (i_cmd_char >= CHR_MODE_LO) && (i_cmd_char <= CHR_MODE_HI);
        y_char = i_cmd_valid && (pstate == P_TERM) && !tac_term_forbidden(i_cmd_char); // RULE16
        y_end = i_cmd_valid && (pstate == P_TERM) && tac_term_forbidden(i_cmd_char); // RULE16
        idle_char = i_cmd_valid && ((pstate == P_IDLE) || y_end);
        x_exec = idle_char && (i_cmd_char == CMD_EXEC);
        y_len = (y_c0 == CHR_DEL) ? 2'h0 : y_cnt; // RULE18
        y_good = y_end && !y_ovf && (y_cnt != 2'h0);
        illegal_int = (t_char && !t_ok)
            || (y_end && (y_ovf || (y_cnt == 2'h0)))
            || (y_char && (y_cnt == TERM_LEN_MAX));
    end

    always_comb begin
        next_pstate = pstate;
        case (pstate)
            P_IDLE, P_TERM: begin
                if (idle_char) begin
                    if (i_cmd_char == CMD_TRIG) begin
                        next_pstate = P_TMODE;
                    end else if (i_cmd_char == CMD_TERM) begin
                        next_pstate = P_TERM;
                    end else begin
                        next_pstate = P_IDLE;
                    end
                end
            end
            P_TMODE: begin
                if (i_cmd_valid) begin
                    next_pstate = P_IDLE;
                end
            end
            default: begin
                next_pstate = P_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pstate <= P_IDLE;
        end else if (bus_clear) begin
            pstate <= P_IDLE;
        end else begin
            pstate <= next_pstate;
        end
    end

    // ----------------------------------------------------------------
    // terminator field collection
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            y_cnt <= 2'h0;
            y_c0 <= 8'h00;
            y_c1 <= 8'h00;
            y_ovf <= 1'b0;
        end else if (bus_clear || (idle_char && (i_cmd_char == CMD_TERM))) begin
            y_cnt <= 2'h0;
            y_c0 <= 8'h00;
            y_c1 <= 8'h00;
            y_ovf <= 1'b0;
        end else if (y_char) begin
            if (y_cnt == 2'h0) begin
                y_c0 <= i_cmd_char; // RULE15
                y_cnt <= 2'h1;
            end else if (y_cnt == 2'h1) begin
                y_c1 <= i_cmd_char; // RULE17
                y_cnt <= 2'h2;
            end else begin
                y_ovf <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // pending settings, applied on execute
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_mode <= MODE_DEFAULT;
            pend_mode_vld <= 1'b0;
        end else if (bus_clear || x_exec) begin
            pend_mode_vld <= 1'b0;
        end else if (t_ok) begin
            pend_mode <= i_cmd_char[2:0]; // RULE12
            pend_mode_vld <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_len <= TERM_LEN_DEFAULT;
            pend_c0 <= TERM_C0_DEFAULT;
            pend_c1 <= TERM_C1_DEFAULT;
            pend_term_vld <= 1'b0;
        end else if (bus_clear || x_exec) begin
            pend_term_vld <= 1'b0;
        end else if (y_good) begin
            pend_len <= y_len;
            pend_c0 <= y_c0;
            pend_c1 <= y_c1;
            pend_term_vld <= 1'b1;
        end
    end

    // the old mode judges the execute char itself;
    // the new one rules afterwards
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode <= MODE_DEFAULT;
        end else if (bus_clear) begin
            mode <= MODE_DEFAULT; // RULE9
        end else if (x_exec && pend_mode_vld) begin
            mode <= pend_mode; // RULE12
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            term_len <= TERM_LEN_DEFAULT; // RULE13
            term_c0 <= TERM_C0_DEFAULT;
            term_c1 <= TERM_C1_DEFAULT;
        end else if (bus_clear) begin
            term_len <= TERM_LEN_DEFAULT; // RULE14
            term_c0 <= TERM_C0_DEFAULT;
            term_c1 <= TERM_C1_DEFAULT;
        end else if (x_exec && y_good) begin
            term_len <= y_len; // RULE15
            term_c0 <= y_c0;
            term_c1 <= y_c1;
        end else if (x_exec && pend_term_vld) begin
            term_len <= pend_len; // RULE15
            term_c0 <= pend_c0;
            term_c1 <= pend_c1;
        end
    end

    // ----------------------------------------------------------------
    // trigger stimuli
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= i_ext_trig;
        end
    end

    assign ext_pulse = i_ext_trig && !ext_prev;

    // stimuli outside the selected mode drop out
    assign start_ev = tac_mode_hit(mode, MODE_START_TALK, i_talk_addr) // RULE1 RULE23
        || tac_mode_hit(mode, MODE_START_GET, i_get) // RULE3
        || tac_mode_hit(mode, MODE_START_EXEC, x_exec) // RULE5
        || tac_mode_hit(mode, MODE_START_EXT, ext_pulse) // RULE7
        || (i_panel_key && !o_running); // RULE10
    assign halt_ev = tac_mode_hit(mode, MODE_STOP_TALK, i_talk_addr) // RULE2 RULE23
        || tac_mode_hit(mode, MODE_STOP_GET, i_get) // RULE4
        || tac_mode_hit(mode, MODE_STOP_EXEC, x_exec) // RULE6
        || tac_mode_hit(mode, MODE_STOP_EXT, ext_pulse) // RULE8
        || (i_panel_key && o_running); // RULE10

    // ----------------------------------------------------------------
    // memory sequencer
    // ----------------------------------------------------------------
    // single step moves one location per start and never stays running
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_running <= 1'b0;
            o_mem_loc <= LOC_FIRST;
            o_step_apply <= 1'b0;
            o_cycle_end <= 1'b0;
        end else begin
            o_step_apply <= 1'b0;
            o_cycle_end <= 1'b0;
            if (halt_ev) begin
                o_running <= 1'b0; // RULE10
            end else if (start_ev && !o_running) begin
                o_step_apply <= 1'b1; // RULE10
                if (i_seq_mode == TAC_SEQ_STEP) begin
                    o_mem_loc <= (o_mem_loc >= i_last_loc) ? LOC_FIRST : o_mem_loc + LOC_STEP;
                end else begin
                    o_mem_loc <= LOC_FIRST; // RULE11
                    o_running <= 1'b1;
                end
            end else if (o_running && i_dwell_done) begin
                if (o_mem_loc >= i_last_loc) begin
                    if (i_seq_mode == TAC_SEQ_CONT) begin
                        o_mem_loc <= LOC_FIRST;
                        o_step_apply <= 1'b1;
                    end else begin
                        o_running <= 1'b0; // RULE11
                        o_cycle_end <= 1'b1;
                    end
                end else begin
                    o_mem_loc <= o_mem_loc + LOC_STEP; // RULE11
                    o_step_apply <= 1'b1;
                end
            end
        end
    end

    assign o_trig_mode = mode;

    // ----------------------------------------------------------------
    // error and service request status
    // ----------------------------------------------------------------
    assign err_ev = illegal_int || i_illegal_option;

    // a new error in the poll cycle survives the clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            srq <= 1'b0;
            err <= 1'b0;
            snap <= STATUS_RESET;
        end else begin
            if (err_ev) begin
                err <= 1'b1; // RULE20
            end else if (i_spoll_read) begin
                err <= 1'b0; // RULE21
            end
            if (err_ev && i_srq_err_en) begin
                srq <= 1'b1; // RULE20
                if (!srq) begin
                    snap <= i_live_status;
                end
            end else if (i_spoll_read) begin
                srq <= 1'b0; // RULE21
            end
        end
    end

    // live bits are frozen while a request is pending
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_status_byte <= STATUS_RESET;
        end else begin
            o_status_byte <= srq ? snap : i_live_status;
            o_status_byte[STAT_RQS_BIT] <= srq; // RULE22
            o_status_byte[STAT_ERR_BIT] <= err; // RULE22
        end
    end

    assign o_srq = srq;

    // ----------------------------------------------------------------
    // terminator sender
    // ----------------------------------------------------------------
    assign term_cfg.len = term_len;
    assign term_cfg.c0 = term_c0;
    assign term_cfg.c1 = term_c1;

    tac_term_tx u_term_tx (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .term(term_cfg.tx),
        .i_send(i_fmt_end),
        .i_ready(i_term_ready),
        .o_valid(o_term_valid),
        .o_char(o_term_char),
        .o_done(o_term_done)
    );

endmodule : tac_trig_term

`default_nettype wire

// ---- verif/tac_trig_term_props.sv ----
`default_nettype none
module tac_trig_term_props
    import tac_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // stimuli
    input wire logic i_talk_addr,
    input wire logic i_get,
    input wire logic i_dcl,
    input wire logic i_sdc,
    input wire logic i_spoll_read,
    input wire logic i_cmd_valid,
    input wire logic i_ext_trig,
    input wire logic i_panel_key,
    input wire logic i_dwell_done,
    input wire logic i_srq_err_en,
    input wire logic i_illegal_option,
    // observed outputs
    input wire logic o_running,
    input wire logic o_step_apply,
    input wire logic o_srq,
    input wire logic [2:0] o_trig_mode,
    input wire logic [7:0] o_status_byte
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // no competing stimulus
    logic quiet;
    assign quiet = !i_panel_key && !i_dwell_done && !i_cmd_valid && !i_get;
    sequence s_err_unread;
        i_illegal_option && i_srq_err_en ##1 !i_spoll_read [*3];
    endsequence
    property p_talk_start;
        o_trig_mode == MODE_START_TALK && i_talk_addr && !o_running && quiet |=> o_step_apply;
    endproperty
    a_talk_start: assert property (p_talk_start) else $error("talk did not start");
    property p_talk_stop;
        o_trig_mode == MODE_STOP_TALK && i_talk_addr && o_running && quiet |=> !o_running;
    endproperty
    a_talk_stop: assert property (p_talk_stop) else $error("talk did not halt");
    property p_ext_start;
        $rose(i_ext_trig) && o_trig_mode == MODE_START_EXT && !o_running && quiet |=> o_step_apply;
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("ext pulse did not start");
    property p_ext_stop;
        $rose(i_ext_trig) && o_trig_mode == MODE_STOP_EXT && o_running && quiet |=> !o_running;
    endproperty
    a_ext_stop: assert property (p_ext_stop) else $error("ext pulse did not halt");
    property p_clear_mode;
        (i_dcl || i_sdc) && !i_cmd_valid |=> o_trig_mode == MODE_DEFAULT;
    endproperty
    a_clear_mode: assert property (p_clear_mode) else $error("clear left wrong mode");
    property p_err_status;
        s_err_unread |-> o_status_byte[6:5] == 2'h3 && o_srq;
    endproperty
    a_err_status: assert property (p_err_status) else $error("error not flagged");
    property p_poll_clear;
        o_srq && i_spoll_read && !i_illegal_option && !i_cmd_valid |=> !o_srq ##[0:1] !o_status_byte[6];
    endproperty
    a_poll_clear: assert property (p_poll_clear) else $error("poll did not release");
    property p_mismatch;
        o_trig_mode == MODE_START_GET && i_talk_addr && !o_running && quiet |=> !o_step_apply && !o_running;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("stray stimulus acted");
endmodule : tac_trig_term_props
bind tac_trig_term tac_trig_term_props i_props (.*);
`default_nettype wire

// ---- verif/tac_ctl_model.sv ----
`default_nettype none
module tac_ctl_model
    import tac_pkg::*;
(
    // clock
    input wire logic i_clk,
    // command stream
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_char
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_cmd_valid = 1'h0;
        o_cmd_char = 8'h00;
    end
    // idle line shows the inverse of the last char
    task automatic send(input logic [7:0] c);
        @(posedge i_clk);
        #2;
        o_cmd_valid = 1'h1;
        o_cmd_char = c;
        @(posedge i_clk);
        #2;
        o_cmd_valid = 1'h0;
        o_cmd_char = ~c;
    endtask : send
    // callers hand in only characters allowed as terminators
    task automatic send_term(input logic [7:0] c0, input logic [7:0] c1, input int n);
        send(CMD_TERM);
        send(c0);
        if (n > 1) begin
            send(c1);
        end
        send(CMD_EXEC);
    endtask : send_term
endmodule : tac_ctl_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tac_pkg::*;
    typedef struct packed {logic [2:0] mode; logic [3:0] stim; logic run;} tac_row_t;
    logic i_clk = 1'h0, i_rst_n = 1'h0, i_talk_addr = 1'h0, i_get = 1'h0, i_dcl = 1'h0, i_sdc = 1'h0;
    logic i_spoll_read = 1'h0, i_ext_trig = 1'h0, i_panel_key = 1'h0, i_dwell_done = 1'h0, i_srq_err_en = 1'h0;
    logic i_illegal_option = 1'h0, i_fmt_end = 1'h0, i_term_ready = 1'h1, i_cmd_valid;
    tac_seq_mode_t i_seq_mode = TAC_SEQ_CONT;
    logic [6:0] i_last_loc = 7'h03;
    logic [7:0] i_live_status = 8'h00, i_cmd_char, o_status_byte, o_term_char;
    logic o_running, o_step_apply, o_cycle_end, o_srq, o_term_valid, o_term_done;
    logic [6:0] o_mem_loc;
    logic [2:0] o_trig_mode;
    int err_total = 0;
    int n_compared = 0;
    // start rows begin halted, stop rows running; last two are foreign
    tac_row_t rows [10] = '{'{3'h0, 4'h0, 1'h1}, '{3'h1, 4'h0, 1'h0}, '{3'h2, 4'h1, 1'h1}, '{3'h3, 4'h1, 1'h0},
        '{3'h4, 4'h2, 1'h1}, '{3'h5, 4'h2, 1'h0}, '{3'h6, 4'h3, 1'h1}, '{3'h7, 4'h3, 1'h0},
        '{3'h2, 4'h0, 1'h0}, '{3'h7, 4'h1, 1'h1}};
    always #25 i_clk = ~i_clk;
    tac_ctl_model i_ctl (.i_clk, .o_cmd_valid(i_cmd_valid), .o_cmd_char(i_cmd_char));
    tac_trig_term i_dut (.*);
    task automatic tick();
        @(posedge i_clk);
        #2;
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stim(input int k);
        if (k == 2) begin
            i_ctl.send(CMD_EXEC);
        end else begin
            tick();
            case (k)
                0: i_talk_addr = 1'h1;
                1: i_get = 1'h1;
                3: i_ext_trig = 1'h1;
                4: i_panel_key = 1'h1;
                5: i_dwell_done = 1'h1;
                6: i_illegal_option = 1'h1;
                7: i_spoll_read = 1'h1;
                8: i_dcl = 1'h1;
                default: i_sdc = 1'h1;
            endcase
            tick();
            {i_talk_addr, i_get, i_ext_trig, i_panel_key, i_dwell_done, i_illegal_option} = 6'h00;
            {i_spoll_read, i_dcl, i_sdc} = 3'h0;
        end
    endtask : stim
    // formatter stalls every other cycle
    task automatic term(input logic [15:0] exp, input int n);
        logic [15:0] got = 16'h0000;
        int cnt = 0;
        tick();
        i_fmt_end = 1'h1;
        tick();
        i_fmt_end = 1'h0;
        for (int k = 0; k < 12 && o_term_done !== 1'h1; k++) begin
            i_term_ready = k[0];
            @(negedge i_clk);
            if (o_term_valid === 1'h1 && i_term_ready) begin
                got = {got[7:0], o_term_char};
                cnt++;
            end
            tick();
        end
        chk(got, exp);
        chk(16'(cnt), 16'(n));
    endtask : term
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        #(4000 * 50);
        err_total++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        #2;
        i_rst_n = 1'h1;
        chk(16'({o_trig_mode, o_mem_loc, o_running}), 16'({3'h6, 7'h01, 1'h0}));
        term(16'h0D0A, 2);
        $display("reset test done");
        for (int r = 0; r < 10; r++) begin
            i_ctl.send(CMD_TRIG);
            i_ctl.send(CHR_MODE_LO + 8'(rows[r].mode));
            i_ctl.send(CMD_EXEC);
            tick();
            if (o_running !== rows[r].mode[0]) begin
                stim(4);
            end
            chk(16'(o_trig_mode), 16'(rows[r].mode));
            stim(int'(rows[r].stim));
            tick();
            chk(16'(o_running), 16'(rows[r].run));
        end
        $display("trigger table done");
        i_ctl.send_term(CHR_LF, CHR_CR, 2);
        term(16'h0A0D, 2);
        i_ctl.send_term(8'h21, 8'h00, 1);
        term(16'h0021, 1);
        i_ctl.send_term(CHR_DEL, 8'h00, 1);
        term(16'h0000, 0);
        stim(9);
        term(16'h0D0A, 2);
        $display("terminator test done");
        if (o_running === 1'h1) begin
            stim(4);
        end
        i_seq_mode = TAC_SEQ_CYCLE;
        stim(4);
        chk(16'({o_mem_loc, o_step_apply, o_running}), 16'h0007);
        for (int k = 2; k < 4; k++) begin
            stim(5);
            chk(16'({o_mem_loc, o_step_apply}), 16'({7'(k), 1'h1}));
        end
        stim(5);
        chk(16'({o_cycle_end, o_running}), 16'h0002);
        $display("single cycle test done");
        i_srq_err_en = 1'h1;
        for (int s = 0; s < 2; s++) begin
            if (s == 0) begin
                stim(6);
            end else begin
                i_ctl.send(CMD_TRIG);
                i_ctl.send(8'h39);
            end
            repeat (3) tick();
            chk(16'({o_srq, o_status_byte[6:5]}), 16'h0007);
            stim(7);
            repeat (2) tick();
            chk(16'({o_srq, o_status_byte[6:5]}), 16'h0000);
        end
        $display("status test done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
